// *** pin_sync.sv ***
// Three-stage input synchroniser that accepts a change on agreement.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   logic [WIDTH-1:0] next_level;

   always_comb begin
      next_level = level_o;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2[i] == s3[i]) begin
            next_level[i] = s3[i];
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         // The pins idle high through their pull-ups, so starting at ones
         // avoids a false low level for the first cycles after reset.
         s1 <= '1;
         s2 <= '1;
         s3 <= '1;
         level_o <= '1;
      end else if (ce_i) begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         level_o <= next_level;
      end
   end
endmodule

// *** rail_enable_regs.sv ***
// Register slice holding the rail enables, unlock and wake flag.
`timescale 1ns/1ps
module rail_enable_regs (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire rail_pkg::reg_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   input wire rail_pkg::seq_update_t seq_i,
   input wire logic freshness_seal_i,
   input wire logic pin_one_input_select_i,
   input wire logic warm_reset_pin_enable_i,
   input wire logic wake_from_suspend_i,
   input wire logic buck_one_in_suspend_i,
   input wire logic general_pin_one_i,
   input wire logic general_pin_three_i,
   output logic [7:0] buck_enable_o,
   output logic [7:0] switch_output_enable_o,
   output logic general_pin_one_o,
   output logic general_pin_one_oe_o,
   output logic general_out_two_o,
   output logic general_out_two_oe_o,
   output logic general_pin_three_o,
   output logic general_pin_three_oe_o,
   output logic warm_reset_o,
   output logic buck_one_suspend_flag_o
);

   // ------------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------------
   logic [1:0] pin_level;

   pin_sync #(.WIDTH(2)) u_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i({general_pin_three_i, general_pin_one_i}),
      .level_o(pin_level)
   );

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [7:0] buck_enable;
   logic [7:0] switch_output_enable;
   logic unlocked;
   logic buck_one_suspend_flag;
   logic [7:0] next_buck_enable;
   logic [7:0] next_switch_output_enable;
   logic next_unlocked;
   logic next_flag;
   logic [7:0] next_rdata;
   logic next_rvalid;
   logic [7:0] wr_buck;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   always_comb begin
      next_buck_enable = buck_enable;
      next_switch_output_enable = switch_output_enable;
      next_unlocked = unlocked;
      next_flag = buck_one_suspend_flag;
      next_rdata = 8'h00;
      next_rvalid = req_i.rd;
      wr_buck = req_i.wdata & rail_pkg::BUCK_WRITE_MASK;
      // Software writes cannot clear bucks five and six while the seal is set; the sequencer below can still clear buck five.
      if (freshness_seal_i) begin
         wr_buck[rail_pkg::BUCK_SIX_BIT] = wr_buck[rail_pkg::BUCK_SIX_BIT]
            | buck_enable[rail_pkg::BUCK_SIX_BIT];
         wr_buck[rail_pkg::BUCK_FIVE_BIT] = wr_buck[rail_pkg::BUCK_FIVE_BIT]
            | buck_enable[rail_pkg::BUCK_FIVE_BIT];
      end
      if (req_i.wr) begin
         if (hit(req_i.addr, rail_pkg::UNLOCK_KEY_ADDR)) begin
            next_unlocked = (req_i.wdata == rail_pkg::UNLOCK_MAGIC);
         end else if (hit(req_i.addr, rail_pkg::BUCK_ENABLE_ADDR)) begin
            if (unlocked) begin
               next_buck_enable = wr_buck;
            end
            next_unlocked = 1'b0;
         end else if (hit(req_i.addr, rail_pkg::SWITCH_OUTPUT_ENABLE_ADDR))
         begin
            if (unlocked) begin
               next_switch_output_enable = req_i.wdata
                  & rail_pkg::SWITCH_WRITE_MASK;
            end
            next_unlocked = 1'b0;
         end
      end
      // The sequencer wins over a software write in the same cycle, since
      // the rail state it reports is what is physically on.
      if (seq_i.valid) begin
         next_buck_enable = (next_buck_enable & ~rail_pkg::BUCK_SEQ_MASK)
            | (seq_i.buck_on & rail_pkg::BUCK_SEQ_MASK);
         next_switch_output_enable = (next_switch_output_enable
            & ~rail_pkg::SWITCH_SEQ_MASK)
            | (seq_i.switch_on & rail_pkg::SWITCH_SEQ_MASK);
      end
      // The flag is captured at each wake; it holds until the next one.
      if (wake_from_suspend_i) begin
         next_flag = buck_one_in_suspend_i;
      end
      if (req_i.rd) begin
         unique case (req_i.addr)
            rail_pkg::UNLOCK_KEY_ADDR: next_rdata = rail_pkg::UNLOCK_READBACK;
            rail_pkg::BUCK_ENABLE_ADDR: next_rdata = buck_enable;
            rail_pkg::SWITCH_OUTPUT_ENABLE_ADDR:
               next_rdata = switch_output_enable;
            rail_pkg::WAKE_SOURCE_FLAGS_ADDR:
               next_rdata = {7'h00, buck_one_suspend_flag};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         buck_enable <= rail_pkg::BUCK_ENABLE_RESET;
         switch_output_enable <= rail_pkg::SWITCH_OUTPUT_ENABLE_RESET;
         unlocked <= 1'b0;
         buck_one_suspend_flag <= 1'b0;
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
      end else if (ce_i) begin
         buck_enable <= next_buck_enable;
         switch_output_enable <= next_switch_output_enable;
         unlocked <= next_unlocked;
         buck_one_suspend_flag <= next_flag;
         rdata_o <= next_rdata;
         rvalid_o <= next_rvalid;
      end
   end

   // ------------------------------------------------------------------
   // General pin drivers
   // ------------------------------------------------------------------
   logic next_one_oe;
   logic next_two_oe;
   logic next_three_oe;
   logic next_warm;

   always_comb begin
      // Open-drain: drive low when the bit is 0, release when 1.
      next_one_oe = ~switch_output_enable[rail_pkg::PIN_ONE_BIT];
      next_two_oe = ~switch_output_enable[rail_pkg::PIN_TWO_BIT];
      next_three_oe = ~switch_output_enable[rail_pkg::PIN_THREE_BIT];
      next_warm = 1'b0;
      if (pin_one_input_select_i) begin
         next_one_oe = 1'b0;
         next_two_oe = ~pin_level[0];
      end
      if (warm_reset_pin_enable_i) begin
         next_three_oe = 1'b0;
         next_warm = ~pin_level[1];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         general_pin_one_oe_o <= 1'b0;
         general_out_two_oe_o <= 1'b0;
         general_pin_three_oe_o <= 1'b0;
         warm_reset_o <= 1'b0;
         buck_enable_o <= 8'h00;
         switch_output_enable_o <= 8'h00;
         buck_one_suspend_flag_o <= 1'b0;
         general_pin_one_o <= 1'b0;
         general_out_two_o <= 1'b0;
         general_pin_three_o <= 1'b0;
      end else if (ce_i) begin
         general_pin_one_oe_o <= next_one_oe;
         general_out_two_oe_o <= next_two_oe;
         general_pin_three_oe_o <= next_three_oe;
         warm_reset_o <= next_warm;
         buck_enable_o <= next_buck_enable;
         switch_output_enable_o <= next_switch_output_enable;
         buck_one_suspend_flag_o <= next_flag;
         general_pin_one_o <= 1'b0;
         general_out_two_o <= 1'b0;
         general_pin_three_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   unlock_reads_zero_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && req_i.rd
      && req_i.addr == rail_pkg::UNLOCK_KEY_ADDR |=> rdata_o == 8'h00)
      else $error("unlock register read back nonzero");
   buck_reserved_zero_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) buck_enable[7:6] == 2'b00)
      else $error("buck reserved bits set");
   switch_reserved_zero_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) switch_output_enable[7] == 1'b0)
      else $error("switch reserved bit set");
   seal_holds_six_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && freshness_seal_i && buck_enable[5]
      |=> buck_enable[5])
      else $error("buck six cleared while sealed");
   seal_holds_five_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && freshness_seal_i && !seq_i.valid
      && buck_enable[4] |=> buck_enable[4])
      else $error("buck five cleared while sealed");
   locked_write_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && !unlocked && !seq_i.valid && req_i.wr
      && req_i.addr == rail_pkg::BUCK_ENABLE_ADDR
      |=> $stable(buck_enable))
      else $error("locked write changed buck enables");
   seq_tracks_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && seq_i.valid
      |=> buck_enable[4:0] == $past(seq_i.buck_on[4:0]))
      else $error("sequencer update not tracked");
   pin_two_follow_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && !pin_one_input_select_i
      |=> general_out_two_oe_o == !$past(switch_output_enable[5]))
      else $error("output two does not follow its bit");
   pin_one_input_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && pin_one_input_select_i
      |=> !general_pin_one_oe_o)
      else $error("pin one driven while input");
   warm_release_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && warm_reset_pin_enable_i
      |=> !general_pin_three_oe_o)
      else $error("pin three driven while warm reset input");
   warm_follow_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && warm_reset_pin_enable_i
      |=> warm_reset_o == !$past(pin_level[1]))
      else $error("warm reset does not follow pin three");
   flag_capture_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && wake_from_suspend_i
      |=> buck_one_suspend_flag_o == $past(buck_one_in_suspend_i))
      else $error("wake flag not captured");
   switch_locked_a: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ce_i && !unlocked && !seq_i.valid && req_i.wr
      && req_i.addr == rail_pkg::SWITCH_OUTPUT_ENABLE_ADDR
      |=> $stable(switch_output_enable))
      else $error("locked write changed switch enables");
endmodule

// *** rail_host_model.sv ***
// Host model that issues single-byte accesses to the rail register slice.
`timescale 1ns/1ps
module rail_host_model (
   input wire logic core_clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output rail_pkg::reg_req_t req_o
);
   initial req_o = '0;

   // Released address and data show the inverse, never a stale value.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_i);
      #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // Every protected write carries its own unlock directly before it.
   task automatic pwr(input logic [7:0] a, input logic [7:0] d);
      wr(rail_pkg::UNLOCK_KEY_ADDR, rail_pkg::UNLOCK_MAGIC);
      wr(a, d);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge core_clk_i);
      #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
   endtask
endmodule

// *** rail_pkg.sv ***
// Package of constants and carrier types for the rail enable register slice.
// What this block does
// - Wake flag bit 0 is 1 only after suspend wake with buck one on.
// - Unlock register at 0x10, eight bits, resets to zero.
// - Reading the unlock register always returns zero.
// - Buck enable register at 0x11 resets zero; bits 7-6 read zero.
// - Clearing buck six enable is ignored unless the freshness seal is 0.
// - A software clear of buck five enable is ignored unless the freshness seal is 0; a sequencer update clears it regardless.
// - Sequencer writes buck one-five, switch one and linear enables.
// - Switch/output register at 0x12 resets zero; bit 7 reads zero.
// - Bit 6 drives pin three low or releases it, unless warm reset set.
// - Bit 5 drives output two low or releases it, unless input select set.
// - Bit 4 drives pin one low or releases it, unless input select set.
// - With input select set, pin one input drives output two through the pin synchroniser.
// - With warm reset set, pin three is a warm reset input to bucks 1-2.
package rail_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] UNLOCK_KEY_ADDR = 8'h10;
   localparam logic [7:0] BUCK_ENABLE_ADDR = 8'h11;
   localparam logic [7:0] SWITCH_OUTPUT_ENABLE_ADDR = 8'h12;
   localparam logic [7:0] WAKE_SOURCE_FLAGS_ADDR = 8'h07;
   localparam logic [7:0] UNLOCK_KEY_RESET = 8'h00;
   localparam logic [7:0] BUCK_ENABLE_RESET = 8'h00;
   localparam logic [7:0] SWITCH_OUTPUT_ENABLE_RESET = 8'h00;
   localparam logic [7:0] UNLOCK_READBACK = 8'h00;
   // Value written to the unlock register that arms one protected write.
   localparam logic [7:0] UNLOCK_MAGIC = 8'h7d;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int BUCK_ONE_BIT = 0;
   localparam int BUCK_FIVE_BIT = 4;
   localparam int BUCK_SIX_BIT = 5;
   localparam int LINEAR_REG_BIT = 0;
   localparam int SWITCH_ONE_BIT = 1;
   localparam int PIN_ONE_BIT = 4;
   localparam int PIN_TWO_BIT = 5;
   localparam int PIN_THREE_BIT = 6;
   localparam logic [7:0] BUCK_WRITE_MASK = 8'h3f;
   localparam logic [7:0] SWITCH_WRITE_MASK = 8'h7f;
   // Bits the sequencer owns: bucks one to five, switch one, linear reg.
   localparam logic [7:0] BUCK_SEQ_MASK = 8'h1f;
   localparam logic [7:0] SWITCH_SEQ_MASK = 8'h03;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] buck_on;
      logic [7:0] switch_on;
   } seq_update_t;

endpackage

// *** test_rail_enable_regs.sv ***
// Self-checking testbench for the rail enable register slice.
`timescale 1ns/1ps
module test_rail_enable_regs;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   rail_pkg::reg_req_t req;
   rail_pkg::seq_update_t seq = '0;
   logic [7:0] rdata, buck_en, sw_en, v;
   logic rvalid, seal = 1'b0, sel = 1'b0, warm = 1'b0;
   logic wake = 1'b0, susp = 1'b0, ext_one = 1'b1, ext_three = 1'b1;
   logic ce = 1'b1;
   logic p1_o, p1_oe, o2_o, o2_oe, p3_o, p3_oe, warm_rst, flag;
   int fails = 0;
   int n_compared = 0;

   always #50 core_clk_i = ~core_clk_i;

   rail_host_model i_host (
      .core_clk_i(core_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
      .req_o(req));

   // Open-drain pins: the device pulls low, otherwise the outside drives.
   rail_enable_regs i_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce), .req_i(req),
      .rdata_o(rdata), .rvalid_o(rvalid), .seq_i(seq),
      .freshness_seal_i(seal), .pin_one_input_select_i(sel),
      .warm_reset_pin_enable_i(warm), .wake_from_suspend_i(wake),
      .buck_one_in_suspend_i(susp),
      .general_pin_one_i(p1_oe ? 1'b0 : ext_one),
      .general_pin_three_i(p3_oe ? 1'b0 : ext_three),
      .buck_enable_o(buck_en), .switch_output_enable_o(sw_en),
      .general_pin_one_o(p1_o), .general_pin_one_oe_o(p1_oe),
      .general_out_two_o(o2_o), .general_out_two_oe_o(o2_oe),
      .general_pin_three_o(p3_o), .general_pin_three_oe_o(p3_oe),
      .warm_reset_o(warm_rst), .buck_one_suspend_flag_o(flag));

   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      tick(3);
      rst_i = 1'b0;
      i_host.rd(8'h10, v); check("unlock reset", v, 8'h00);
      i_host.rd(8'h11, v); check("buck reset", v, 8'h00);
      i_host.rd(8'h12, v); check("switch reset", v, 8'h00);
      $display("test reset values done");
      i_host.wr(8'h10, 8'h5a);
      i_host.rd(8'h10, v); check("unlock read", v, 8'h00);
      i_host.wr(8'h11, 8'hff);
      tick(1); check("locked write", buck_en, 8'h00);
      i_host.wr(8'h12, 8'h7f);
      tick(1); check("locked switch", sw_en, 8'h00);
      i_host.pwr(8'h11, 8'hff);
      i_host.rd(8'h11, v); check("buck all", v, 8'h3f);
      $display("test unlock done");
      seal = 1'b1;
      i_host.pwr(8'h11, 8'h00);
      i_host.rd(8'h11, v); check("sealed clear", v, 8'h30);
      seal = 1'b0;
      i_host.pwr(8'h11, 8'h0f);
      tick(1); check("unsealed clear", buck_en, 8'h0f);
      $display("test seal done");
      @(posedge core_clk_i);
      #1 seq = '{valid: 1'b1, buck_on: 8'h1f, switch_on: 8'h03};
      tick(1);
      seq.valid = 1'b0;
      tick(1); check("seq buck", buck_en, 8'h1f);
      check("seq switch", sw_en, 8'h03);
      $display("test sequencer done");
      ce = 1'b0;
      i_host.pwr(8'h11, 8'h00);
      ce = 1'b1;
      tick(1); check("frozen write", buck_en, 8'h1f);
      $display("test clock enable done");
      i_host.pwr(8'h12, 8'hff);
      i_host.rd(8'h12, v); check("switch all", v, 8'h7f);
      tick(2); check("pins hiz", {p1_oe, o2_oe, p3_oe}, 8'h00);
      i_host.pwr(8'h12, 8'h0f);
      tick(2); check("pins low", {p1_oe, o2_oe, p3_oe}, 8'h07);
      check("pin level", {p1_o, o2_o, p3_o}, 8'h00);
      sel = 1'b1;
      ext_one = 1'b0;
      tick(6); check("pin one low", {p1_oe, o2_oe}, 8'h01);
      ext_one = 1'b1;
      tick(6); check("pin one high", {p1_oe, o2_oe}, 8'h00);
      warm = 1'b1;
      ext_three = 1'b0;
      tick(6); check("warm low", {p3_oe, warm_rst}, 8'h01);
      ext_three = 1'b1;
      tick(6); check("warm high", {p3_oe, warm_rst}, 8'h00);
      $display("test pins done");
      susp = 1'b1;
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      tick(1); check("wake flag", flag, 8'h01);
      i_host.rd(8'h07, v); check("wake read", v, 8'h01);
      susp = 1'b0;
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      tick(1); check("cold flag", flag, 8'h00);
      $display("test wake flag done");
      rst_i = 1'b1;
      tick(2);
      rst_i = 1'b0;
      check("reset buck", buck_en, 8'h00);
      check("reset switch", sw_en, 8'h00);
      tick(1); check("reset warm", warm_rst, 8'h00);
      $display("test mid-run reset done");
      end_of_test;
   end

   // Tests need under a hundred cycles; five thousand means a hang.
   initial begin
      #500000;
      fails++;
      end_of_test;
   end
endmodule
